// >>> shared/vpwm_pkg.sv
// Constants and carrier types for the voltage PWM amplitude scaling block
package vpwm_pkg;
   // ****************************************
   // Register map (APB byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CONF = 8'h00;
   localparam logic [7:0] ADDR_STEPIV = 8'h04;
   localparam logic [7:0] ADDR_CURR = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   // CONF fields
   localparam int CONF_AMPL_LSB = 0;
   localparam int CONF_GRAD_LSB = 8;
   localparam int CONF_FREQ_LSB = 16;
   localparam int CONF_BLANK_LSB = 18;
   localparam int CONF_AUTO_BIT = 20;
   // CURR fields
   localparam int CURR_RUN_LSB = 0;
   localparam int CURR_HOLD_LSB = 8;
   localparam int CURR_VREF_LSB = 16;
   localparam int CURR_STILL_BIT = 24;
   // Reset values
   localparam logic [7:0] AMPL_RST = 8'h80;
   localparam logic [7:0] GRAD_RST = 8'h04;
   localparam logic [1:0] FREQ_RST = 2'h0;
   localparam logic [1:0] BLANK_RST = 2'h1;
   localparam logic AUTO_RST = 1'b1;
   localparam logic [4:0] RUN_RST = 5'h10;
   localparam logic [4:0] HOLD_RST = 5'h08;
   localparam logic [7:0] VREF_RST = 8'hFF;
   localparam logic [19:0] STEPIV_RST = 20'hFFFFF;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 200;
   // Full PWM period in clocks per code (two cycles per count period)
   localparam logic [10:0] PER_F0 = 11'h400;
   localparam logic [10:0] PER_F1 = 11'h2AB;
   localparam logic [10:0] PER_F2 = 11'h200;
   localparam logic [10:0] PER_F3 = 11'h19A;
   // Blanking clocks per code
   localparam logic [7:0] BLANK_C0 = 8'h10;
   localparam logic [7:0] BLANK_C1 = 8'h18;
   localparam logic [7:0] BLANK_C2 = 8'h24;
   localparam logic [7:0] BLANK_C3 = 8'h36;
   localparam logic [8:0] SINE_PEAK = 9'h0F8;
   localparam logic [7:0] SCALE_MAX = 8'hFF;
   localparam logic [4:0] RUN_MIN = 5'h08;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic autoscale;
      logic [1:0] blanking_time_select;
      logic [1:0] chopper_frequency_divider;
      logic [7:0] amplitude_gradient_gain;
      logic [7:0] base_voltage_amplitude;
   } pwm_conf_t;
   typedef struct packed {
      logic standstill;
      logic [7:0] vref_scale;
      logic [4:0] hold_current_scale;
      logic [4:0] run_current_scale;
   } curr_conf_t;
   typedef enum logic [1:0] {PH_BLANK, PH_MEAS, PH_OFF} phase_t;
endpackage

// >>> verilog/vpwm_amplitude.sv
// Voltage PWM amplitude scaling with APB register access
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vpwm_amplitude
   import vpwm_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic step_pulse,
   input wire logic [7:0] coil_current,
   output logic pwm_out,
   output logic [7:0] pwm_scale,
   output logic low_duty
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [10:0] period_of(input logic [1:0] code);
      case (code)
         2'h0: period_of = PER_F0;
         2'h1: period_of = PER_F1;
         2'h2: period_of = PER_F2;
         default: period_of = PER_F3;
      endcase
   endfunction
   function automatic logic [7:0] blank_of(input logic [1:0] code);
      case (code)
         2'h0: blank_of = BLANK_C0;
         2'h1: blank_of = BLANK_C1;
         2'h2: blank_of = BLANK_C2;
         default: blank_of = BLANK_C3;
      endcase
   endfunction
   function automatic logic [7:0] sat8(input logic [23:0] v);
      sat8 = (v > 24'(SCALE_MAX)) ? SCALE_MAX : v[7:0];
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   pwm_conf_t conf_q;
   curr_conf_t curr_q;
   logic [19:0] step_interval_count_q;
   logic [19:0] step_cnt_q;
   logic [7:0] scale_q;
   logic collapsed_q;
   logic wr_en;
   logic addr_ok;
   assign addr_ok = (paddr == ADDR_CONF) || (paddr == ADDR_STEPIV) ||
                    (paddr == ADDR_CURR) || (paddr == ADDR_STAT);
   assign wr_en = psel && penable && pwrite && addr_ok;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         conf_q <= '{AUTO_RST, BLANK_RST, FREQ_RST, GRAD_RST, AMPL_RST};
         curr_q <= '{1'b0, VREF_RST, HOLD_RST, RUN_RST};
      end
      else if (wr_en && paddr == ADDR_CONF)
      begin
         conf_q.base_voltage_amplitude <= pwdata[CONF_AMPL_LSB +: 8];
         conf_q.amplitude_gradient_gain <= pwdata[CONF_GRAD_LSB +: 8];
         conf_q.chopper_frequency_divider <= pwdata[CONF_FREQ_LSB +: 2];
         conf_q.blanking_time_select <= pwdata[CONF_BLANK_LSB +: 2];
         conf_q.autoscale <= pwdata[CONF_AUTO_BIT];
      end
      else if (wr_en && paddr == ADDR_CURR)
      begin
         curr_q.run_current_scale <= pwdata[CURR_RUN_LSB +: 5];
         curr_q.hold_current_scale <= pwdata[CURR_HOLD_LSB +: 5];
         curr_q.vref_scale <= pwdata[CURR_VREF_LSB +: 8];
         curr_q.standstill <= pwdata[CURR_STILL_BIT];
      end
   end

   // Single-cycle access: pready is set in the access phase
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               ADDR_CONF: prdata <= {11'h0, conf_q};
               ADDR_STEPIV: prdata <= {12'h0, step_interval_count_q};
               ADDR_CURR: prdata <= {7'h0, curr_q.standstill, curr_q.vref_scale, 3'h0,
                                     curr_q.hold_current_scale, 3'h0, curr_q.run_current_scale};
               ADDR_STAT: prdata <= {22'h0, low_duty, collapsed_q, scale_q};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************
   // Step interval measurement
   // ****************************************
   logic [2:0] step_sync_q;
   logic step_seen;
   // Third and second stage must agree high with previous low to count once
   assign step_seen = step_sync_q[2] && step_sync_q[1];
   logic step_prev_q;
   logic step_rise;
   assign step_rise = step_seen && !step_prev_q;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         step_sync_q <= 3'h0;
         step_prev_q <= 1'b0;
      end
      else
      begin
         step_sync_q <= {step_sync_q[1:0], step_pulse};
         step_prev_q <= step_seen;
      end
   end

   // Interval in clocks; a stalled motor saturates at 20'hFFFFE, one below STEPIV_RST
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         step_cnt_q <= 20'h0;
         step_interval_count_q <= STEPIV_RST;
      end
      else if (step_rise)
      begin
         step_cnt_q <= 20'h1;
         step_interval_count_q <= step_cnt_q;
      end
      else if (step_cnt_q != STEPIV_RST)
      begin
         step_cnt_q <= step_cnt_q + 20'h1;
         if (step_cnt_q >= step_interval_count_q)
            step_interval_count_q <= step_cnt_q;
      end
   end

   // ****************************************
   // PWM timebase and phases
   // ****************************************
   phase_t phase_q;
   logic [10:0] pwm_cnt_q;
   logic second_q;
   logic [10:0] period;
   logic [10:0] half_len;
   logic [7:0] blank;
   logic [10:0] on_len;
   logic period_end;
   assign period = period_of(conf_q.chopper_frequency_divider);
   assign blank = blank_of(conf_q.blanking_time_select);
   // Two PWM cycles per period; an odd period gives its spare clock to the second
   assign half_len = second_q ? (period - (period >> 1)) : (period >> 1);
   // On time of the full-scale sine peak, 248/256 of the half period
   assign on_len = 11'((27'(period) * 27'(scale_q) * 27'(SINE_PEAK)) >> 17);
   // End of one PWM cycle
   assign period_end = (pwm_cnt_q >= half_len - 11'h001);

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pwm_cnt_q <= 11'h000;
         second_q <= 1'b0;
      end
      else if (period_end)
      begin
         pwm_cnt_q <= 11'h000;
         second_q <= !second_q;
      end
      else
         pwm_cnt_q <= pwm_cnt_q + 11'h001;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         phase_q <= PH_BLANK;
      else
      begin
         case (phase_q)
            PH_BLANK: if (pwm_cnt_q >= on_len) phase_q <= PH_OFF;
                      else if (pwm_cnt_q >= 11'(blank)) phase_q <= PH_MEAS;
            PH_MEAS: if (pwm_cnt_q >= on_len) phase_q <= PH_OFF;
            PH_OFF: if (period_end) phase_q <= PH_BLANK;
            default: phase_q <= PH_BLANK;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pwm_out <= 1'b0;
      else
         pwm_out <= (phase_q != PH_OFF) && (on_len != 11'h0);
   end

   // ****************************************
   // Amplitude computation
   // ****************************************
   logic [7:0] target;
   logic [7:0] target_min;
   logic [7:0] target_raw;
   logic [4:0] cs;
   logic [23:0] vel_term;
   logic [7:0] vel_scale;
   logic meas_ok_q;
   logic [7:0] meas_q;
   assign cs = curr_q.standstill ? curr_q.hold_current_scale : curr_q.run_current_scale;
   // Target current in coil-current units, scaled by the analog reference
   assign target_raw = 8'((16'({cs, 3'h0}) * 16'(curr_q.vref_scale)) >> 8);
   // Least measurable target grows with blanking share of the period
   assign target_min = 8'((16'(blank) * 16'h0200) / 16'(period));
   assign target = (target_raw < target_min) ? target_min : target_raw;
   // grad*256*fstep/fclk with fstep = fclk/interval
   assign vel_term = (24'(conf_q.amplitude_gradient_gain) << 8) /
                     24'((step_interval_count_q == 20'h0) ? 20'h1 : step_interval_count_q);
   assign vel_scale = sat8(24'(conf_q.base_voltage_amplitude) + vel_term);

   // Latch current only while measuring after blanking
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         meas_q <= 8'h0;
         meas_ok_q <= 1'b0;
      end
      else
      begin
         // Sample flag lives until the cycle end; a new sample wins over the clear
         if (phase_q == PH_MEAS && conf_q.autoscale)
         begin
            meas_q <= coil_current;
            meas_ok_q <= 1'b1;
         end
         else if (period_end)
            meas_ok_q <= 1'b0;
      end
   end

   logic [9:0] scale_next;
   logic signed [9:0] err;
   logic signed [17:0] corr;
   logic signed [17:0] scale_sum;
   assign err = $signed({2'b0, target}) - $signed({2'b0, meas_q});
   assign corr = (18'(err) * 18'($signed({2'b0, conf_q.amplitude_gradient_gain}))) >>> 3;
   assign scale_sum = $signed({10'h000, scale_q}) + corr;
   always_comb
   begin
      // Clamp on the wide sum so a large gain cannot wrap the amplitude
      if (scale_sum < 18'sh00000)
         scale_next = 10'h000;
      else if (scale_sum > 18'sh000FF)
         scale_next = 10'(SCALE_MAX);
      else
         scale_next = scale_sum[9:0];
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         scale_q <= AMPL_RST;
      else if (!conf_q.autoscale)
         scale_q <= vel_scale;
      else if (collapsed_q && curr_q.standstill)
         scale_q <= conf_q.base_voltage_amplitude;
      else if (period_end && meas_ok_q)
         scale_q <= scale_next[7:0];
   end

   // Duty below blanking means no sample can be taken
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         low_duty <= 1'b0;
         collapsed_q <= 1'b0;
      end
      else
      begin
         low_duty <= on_len <= 11'(blank);
         if (!conf_q.autoscale || curr_q.standstill)
            collapsed_q <= 1'b0;
         else if (on_len <= 11'(blank))
            collapsed_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pwm_scale <= AMPL_RST;
      else
         pwm_scale <= scale_q;
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence vel_sel_s;
      !conf_q.autoscale && $stable(conf_q) && $stable(step_interval_count_q);
   endsequence
   vel_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
      vel_sel_s |=> scale_q == $past(vel_scale))
      else $error("velocity amplitude mismatch");
   sat_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
      (24'(conf_q.base_voltage_amplitude) + vel_term > 24'hFF) |-> vel_scale == 8'hFF)
      else $error("velocity amplitude wrapped");
   meas_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
      $changed(meas_q) |-> $past(phase_q) == PH_MEAS)
      else $error("sample outside measure phase");
   hold_still_a: assert property (@(posedge mclk) disable iff (!rstn)
      conf_q.autoscale && !period_end && !curr_q.standstill && !$past(!conf_q.autoscale)
      |=> $stable(scale_q))
      else $error("scale moved mid period");
   floor_min_a: assert property (@(posedge mclk) disable iff (!rstn)
      target >= target_min)
      else $error("target below floor");
   blank_len_a: assert property (@(posedge mclk) disable iff (!rstn)
      conf_q.blanking_time_select == 2'h1 |-> blank == 8'h18)
      else $error("blanking length wrong");
   per_len_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(period_end) && conf_q.chopper_frequency_divider == 2'h0 && $stable(conf_q)
      |-> pwm_cnt_q == 11'h1FF)
      else $error("pwm period wrong");
   recover_a: assert property (@(posedge mclk) disable iff (!rstn)
      conf_q.autoscale && collapsed_q && curr_q.standstill
      |=> scale_q == $past(conf_q.base_voltage_amplitude))
      else $error("no recovery at standstill");
   prop_gain_a: assert property (@(posedge mclk) disable iff (!rstn)
      (meas_q == target) |-> corr == 18'sh00000)
      else $error("nonzero correction at zero error");
endmodule // vpwm_amplitude
`default_nettype wire

// >>> tb/coil_model.sv
// Coil load model feeding measured current back to the scaling block
`timescale 1ns/1ps
`default_nettype none
module coil_model
   import vpwm_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic pwm_out,
   input wire logic [7:0] pwm_scale,
   input wire logic overdrive,
   output logic [7:0] coil_current
);
   logic [3:0] on_cnt_q;
   logic [7:0] noise_q;
   // ****************************************
   // Current shape
   // ****************************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         on_cnt_q <= 4'h0;
         noise_q <= 8'h5A;
         coil_current <= 8'h00;
      end
      else
      begin
         noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5] ^ noise_q[4] ^ noise_q[3]};
         on_cnt_q <= !pwm_out ? 4'h0 : (on_cnt_q == 4'hF) ? on_cnt_q : on_cnt_q + 4'h1;
         // Off phase shows junk, so any sample taken there spoils regulation
         if (!pwm_out)
            coil_current <= ~noise_q;
         // Switching spike inside the shortest blanking window
         else if (on_cnt_q < 4'h8)
            coil_current <= 8'hFF;
         else
            coil_current <= overdrive ? 8'hFF : {1'b0, pwm_scale[7:1]};
      end
   end
endmodule // coil_model
`default_nettype wire

// >>> tb/test_voltage_pwm_amplitude_scaling.sv
// Self-checking bench for the voltage PWM amplitude scaling block
`timescale 1ns/1ps
`default_nettype none
module test_voltage_pwm_amplitude_scaling;
   import vpwm_pkg::*;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic step_pulse = 1'b0, overdrive = 1'b0, pready, pslverr, pwm_out, low_duty, se;
   logic [7:0] paddr = 8'h00, pwm_scale, coil_current, rnd = 8'h4E;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int err_count = 0, n_tests = 0, cyc = 0, step_per = 0, step_cnt = 0;
   int tt[5] = '{40, 40, 100, 257, 999};
   int pt[4] = '{1024, 683, 512, 410};
   int ar[2] = '{8, 16};
   int av[2] = '{8, 128};
   always #2.5 mclk = ~mclk;
   vpwm_amplitude u_vpwm_amplitude (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_pulse(step_pulse), .coil_current(coil_current),
      .pwm_out(pwm_out), .pwm_scale(pwm_scale), .low_duty(low_duty));
   coil_model u_coil_model (.mclk(mclk), .rstn(rstn), .pwm_out(pwm_out),
      .pwm_scale(pwm_scale), .overdrive(overdrive), .coil_current(coil_current));
   // ****************************************
   // Step source, timeout and helpers
   // ****************************************
   always @(posedge mclk)
   begin
      step_cnt <= (step_per == 0 || step_cnt >= step_per - 1) ? 0 : step_cnt + 1;
      step_pulse <= (step_per != 0) && (step_cnt < 4);
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         err_count++;
         $display("BAD %0t run did not finish", $time);
         close_out();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic int vel_exp(input int b, input int g, input int t);
      int s;
      s = b + g * 256 / t;
      return (s > 255) ? 255 : s;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Read data and error are taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic conf(input logic au, input logic [1:0] fr, input logic [7:0] g, b);
      apb(1'b1, ADDR_CONF, {11'h0, au, 2'h1, fr, g, b});
   endtask
   // First edge is skipped since a code change may leave a partial cycle
   task automatic per2(output int p);
      int t0;
      @(posedge pwm_out);
      @(posedge pwm_out);
      t0 = cyc;
      @(posedge pwm_out);
      @(posedge pwm_out);
      p = cyc - t0;
   endtask
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [31:0] exp_q[$];
      int p, b, g, t, e, d, k;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      exp_q = '{{11'h0, AUTO_RST, BLANK_RST, FREQ_RST, GRAD_RST, AMPL_RST}, {12'h0, STEPIV_RST},
         {8'h0, VREF_RST, 3'h0, HOLD_RST, 3'h0, RUN_RST}, 32'h80, 32'h0};
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, exp_q[i]);
         chk({31'h0, se}, {31'h0, i == 4});
      end
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      chk({31'h0, se}, 32'h1);
      apb(1'b0, ADDR_CONF, 32'h0);
      chk(rd, exp_q[0]);
      for (int f = 0; f < 4; f++)
      begin
         conf(1'b0, 2'(f), 8'h00, 8'h80);
         per2(p);
         chk(32'(p), 32'(pt[f]));
         chk({24'h0, pwm_scale}, 32'h80);
      end
      for (int i = 0; i < 5; i++)
      begin
         rnd = lfsr(rnd);
         b = rnd;
         rnd = lfsr(rnd);
         g = (i == 0) ? 255 : (rnd & 8'h3F);
         t = tt[i];
         conf(1'b0, 2'h0, 8'(g), 8'(b));
         step_per <= t;
         repeat (3 * t) @(posedge mclk);
         @(posedge step_pulse);
         repeat (12) @(posedge mclk);
         chk({24'h0, pwm_scale}, 32'(vel_exp(b, g, t)));
         apb(1'b0, ADDR_STEPIV, 32'h0);
         chk(rd, 32'(t));
      end
      step_per <= 0;
      conf(1'b1, 2'h3, 8'h04, 8'h80);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, ADDR_CURR, {8'h0, 8'(av[i]), 3'h0, 5'h08, 3'h0, 5'(ar[i])});
         repeat (30 * 410) @(posedge mclk);
         e = ar[i] * 8 * av[i] / 256;
         e = (e < 24 * 512 / 410) ? 24 * 512 / 410 : e;
         d = int'(pwm_scale) / 2 - e;
         chk(32'(d >= -2 && d <= 2), 32'h1);
      end
      overdrive <= 1'b1;
      repeat (10 * 410) @(posedge mclk);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk({30'h0, rd[9:8]}, 32'h3);
      chk({31'h0, low_duty}, 32'h1);
      overdrive <= 1'b0;
      apb(1'b1, ADDR_CURR, {7'h0, 1'b1, 8'hFF, 3'h0, 5'h08, 3'h0, 5'h10});
      k = 0;
      while (pwm_scale !== 8'h80 && k < 8200)
      begin
         @(posedge mclk);
         k++;
      end
      chk({24'h0, pwm_scale}, 32'h80);
      close_out();
   end
endmodule // test_voltage_pwm_amplitude_scaling
`default_nettype wire
